// [idle_ctrl.sv]
// Function
// - Bit 8 shows instruction_cache port stopped
// - Bit 7 shows DMA/host port stopped
// - Bit 6 shows I/O port stopped
// - Bit 5 shows external memory stopped
// - Bit 4 shows clock generator stopped
// - Bit 3 shows peripheral domain idled
// - Bit 2 shows instruction cache stopped
// - Bit 1 shows DMA and host stopped
// - Bit 0 shows CPU stopped
// - Control bit 13 idles misc modules
// - Control bit 12 idles external memory
// - Control bit 11 idles OS timer
// - Control bit 10 idles watchdog
// - Control bit 9 idles parallel GPIO
// - Enable clear plus IDLE wakes all peripherals
// - IDLE wakes peripherals whose bit is zero
// - Enable selects exactly the chosen peripherals
// - Bits 8..0 select others, bit 4 reserved
// - Clock idle without all others but bit 3 raises bus error
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module idle_ctrl
  import idle_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire reg_req_t bus_req,
  output logic [DATA_W-1:0] rd_data,
  input wire logic idle_instr,
  input wire logic wake_evt,
  input wire logic [NUM_DOM-1:0] domain_stopped,
  output logic [NUM_DOM-1:0] domain_off,
  output logic [NUM_PER-1:0] periph_off,
  output logic bus_err,
  output logic sleep_done
);

  logic [NUM_DOM-1:0] cfg_q;
  logic [NUM_DOM-1:0] cfg_d;
  logic [NUM_PER-1:0] peripheral_idle_control_q;
  logic [NUM_PER-1:0] peripheral_idle_control_d;
  logic [NUM_DOM-1:0] dom_off_q;
  logic [NUM_DOM-1:0] dom_off_d;
  logic [NUM_PER-1:0] per_off_q;
  logic [NUM_PER-1:0] per_off_d;
  logic [NUM_DOM-1:0] status_q;
  logic [NUM_DOM-1:0] status_d;
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;
  logic bus_err_q;
  logic bus_err_d;
  logic sleep_q;
  logic sleep_d;
  pwr_state_t state_q;
  pwr_state_t state_d;

  wire hit_cfg = bus_req.addr == IDLE_CFG_OFS;
  wire hit_status = bus_req.addr == IDLE_STATUS_OFS;
  wire hit_peripheral_idle_control = bus_req.addr == PERIPH_CTRL_OFS;
  wire wr_cfg = bus_req.wr && hit_cfg;
  wire wr_peripheral_idle_control = bus_req.wr && hit_peripheral_idle_control;

  // Clock idle is only legal when every other domain except the peripheral domain (bit 3) idles too
  wire clk_bad = cfg_q[DOM_CLK] && ((cfg_q & CLK_NEEDS_MASK) != CLK_NEEDS_MASK);
  wire idle_take = idle_instr && !clk_bad;
  wire per_en = cfg_q[DOM_PERIPH];

  // Reserved bit 4 is stored but never gates a peripheral
  wire [NUM_PER-1:0] per_sel = per_en ? (peripheral_idle_control_q & PER_SEL_MASK) : PER_NONE;
  wire [NUM_DOM-1:0] pending = dom_off_q & ~domain_stopped;

  wire [DATA_W-1:0] cfg_rd = {{(DATA_W-NUM_DOM){1'b0}}, cfg_q};
  wire [DATA_W-1:0] status_rd = {{(DATA_W-NUM_DOM){1'b0}}, status_q};
  wire [DATA_W-1:0] peripheral_idle_control_rd = {{(DATA_W-NUM_PER){1'b0}}, peripheral_idle_control_q};

  assign cfg_d = wr_cfg ? bus_req.wdata[NUM_DOM-1:0] : cfg_q;
  assign peripheral_idle_control_d = wr_peripheral_idle_control ? (bus_req.wdata[NUM_PER-1:0] & PER_WR_MASK) : peripheral_idle_control_q;

  // A new IDLE reloads every request, so zero bits wake their domains
  assign dom_off_d = idle_take ? cfg_q : (wake_evt ? DOM_NONE : dom_off_q);

  // Peripheral selects apply only through the peripheral enable
  assign per_off_d = idle_take ? per_sel : (wake_evt ? PER_NONE : per_off_q);

  // Status waits for the domain to confirm it has stopped
  assign status_d = dom_off_q & domain_stopped;

  assign bus_err_d = idle_instr && clk_bad;

  assign rd_data_d = !bus_req.rd ? READ_ZERO :
                     hit_status ? status_rd :
                     hit_peripheral_idle_control ? peripheral_idle_control_rd :
                     hit_cfg ? cfg_rd : READ_ZERO;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      RUN_ST: begin
        if (idle_take && (cfg_q != DOM_NONE)) begin
          state_d = STOPPING_ST;
        end
      end
      STOPPING_ST: begin
        // A fresh IDLE reloads the requests, so the old pending set must not end the wait
        if (idle_take) begin
          state_d = (cfg_q != DOM_NONE) ? STOPPING_ST : RUN_ST;
        end else if (wake_evt) begin
          state_d = RUN_ST;
        end else if (pending == DOM_NONE) begin
          state_d = ASLEEP_ST;
        end
      end
      ASLEEP_ST: begin
        if (idle_take) begin
          state_d = (cfg_q != DOM_NONE) ? STOPPING_ST : RUN_ST;
        end else if (wake_evt) begin
          state_d = RUN_ST;
        end
      end
      default: begin
        state_d = RUN_ST;
      end
    endcase
  end

  assign sleep_d = state_d == ASLEEP_ST;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= CFG_RESET;
      peripheral_idle_control_q <= PERIPHERAL_IDLE_CONTROL_RESET;
    end else begin
      cfg_q <= cfg_d;
      peripheral_idle_control_q <= peripheral_idle_control_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dom_off_q <= DOM_NONE;
      per_off_q <= PER_NONE;
      status_q <= DOM_NONE;
    end else begin
      dom_off_q <= dom_off_d;
      per_off_q <= per_off_d;
      status_q <= status_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= READ_ZERO;
      bus_err_q <= 1'b0;
      sleep_q <= 1'b0;
      state_q <= RUN_ST;
    end else begin
      rd_data_q <= rd_data_d;
      bus_err_q <= bus_err_d;
      sleep_q <= sleep_d;
      state_q <= state_d;
    end
  end

  assign rd_data = rd_data_q;
  assign domain_off = dom_off_q;
  assign periph_off = per_off_q;
  assign bus_err = bus_err_q;
  assign sleep_done = sleep_q;

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  chk_status_needs_stop: assert property (
    status_q[DOM_CPU] |-> $past(dom_off_q[DOM_CPU] && domain_stopped[DOM_CPU])
  ) else $error("cpu status set without a stopped domain");

  chk_status_clears_wake: assert property (
    (wake_evt && !idle_instr) |=> ##1 (status_q == DOM_NONE)
  ) else $error("status not cleared after wake");

  chk_clk_port_bit: assert property (
    (dom_off_q[DOM_CLK] && domain_stopped[DOM_CLK]) |=> status_q[DOM_CLK]
  ) else $error("clock generator status missing");

  chk_icport_read: assert property (
    (bus_req.rd && hit_status) |=> (rd_data[DOM_INSTRUCTION_CACHE_PORT] == $past(status_q[DOM_INSTRUCTION_CACHE_PORT]))
  ) else $error("instruction_cache port status read wrong");

  chk_status_upper_zero: assert property (
    (bus_req.rd && hit_status) |=> (rd_data[DATA_W-1:NUM_DOM] == 7'h00)
  ) else $error("reserved status bits not zero");

  chk_bad_clk_error: assert property (
    (idle_instr && clk_bad) |=> (bus_err && $stable(dom_off_q) && $stable(per_off_q))
  ) else $error("bad clock idle not refused");

  chk_good_no_error: assert property (
    (idle_instr && !clk_bad) |=> !bus_err
  ) else $error("bus error on a legal idle");

  chk_misc_select: assert property (
    (idle_take && per_en && peripheral_idle_control_q[PER_MISC]) |=> periph_off[PER_MISC]
  ) else $error("misc modules not idled");

  chk_per_wake_all: assert property (
    (idle_take && !per_en) |=> (periph_off == PER_NONE)
  ) else $error("peripherals not woken with enable clear");

  chk_per_exact: assert property (
    (idle_take && per_en) |=> (periph_off == ($past(peripheral_idle_control_q) & PER_SEL_MASK))
  ) else $error("peripheral selection mismatch");

  chk_reserved_unused: assert property (
    periph_off[4] == 1'b0
  ) else $error("reserved peripheral bit drives an idle");

  chk_sleep_reached: assert property (
    (state_q == STOPPING_ST && pending == DOM_NONE && !wake_evt && !idle_instr)
      |=> sleep_done
  ) else $error("sleep not reported after all domains stopped");

  chk_read_one_cycle: assert property (
    !bus_req.rd |=> (rd_data == READ_ZERO)
  ) else $error("read data outside the read answer cycle");

  chk_master_port_read: assert property (
    (bus_req.rd && hit_status) |=> (rd_data[DOM_MASTER_PORT] == $past(status_q[DOM_MASTER_PORT]))
  ) else $error("master port status read wrong");

  chk_ioport_read: assert property (
    (bus_req.rd && hit_status) |=> (rd_data[DOM_IO_PORT] == $past(status_q[DOM_IO_PORT]))
  ) else $error("io port status read wrong");

  chk_external_memory_interface_read: assert property (
    (bus_req.rd && hit_status) |=> (rd_data[DOM_EXTERNAL_MEMORY_INTERFACE] == $past(status_q[DOM_EXTERNAL_MEMORY_INTERFACE]))
  ) else $error("external memory status read wrong");

  chk_clk_read: assert property (
    (bus_req.rd && hit_status) |=> (rd_data[DOM_CLK] == $past(status_q[DOM_CLK]))
  ) else $error("clock generator status read wrong");

  chk_periph_read: assert property (
    (bus_req.rd && hit_status) |=> (rd_data[DOM_PERIPH] == $past(status_q[DOM_PERIPH]))
  ) else $error("peripheral status read wrong");

  chk_instruction_cache_read: assert property (
    (bus_req.rd && hit_status) |=> (rd_data[DOM_INSTRUCTION_CACHE] == $past(status_q[DOM_INSTRUCTION_CACHE]))
  ) else $error("instruction cache status read wrong");

  chk_dma_read: assert property (
    (bus_req.rd && hit_status) |=> (rd_data[DOM_DMA_HOST] == $past(status_q[DOM_DMA_HOST]))
  ) else $error("dma host status read wrong");

  chk_cpu_read: assert property (
    (bus_req.rd && hit_status) |=> (rd_data[DOM_CPU] == $past(status_q[DOM_CPU]))
  ) else $error("cpu status read wrong");

  chk_external_memory_interface_select: assert property (
    (idle_take && per_en && peripheral_idle_control_q[PER_EXTERNAL_MEMORY_INTERFACE]) |=> periph_off[PER_EXTERNAL_MEMORY_INTERFACE]
  ) else $error("external memory not idled");

  chk_os_timer_select: assert property (
    (idle_take && per_en && peripheral_idle_control_q[PER_OS_TIMER]) |=> periph_off[PER_OS_TIMER]
  ) else $error("os timer not idled");

  chk_watchdog_select: assert property (
    (idle_take && per_en && peripheral_idle_control_q[PER_WDT]) |=> periph_off[PER_WDT]
  ) else $error("watchdog not idled");

  chk_pio_select: assert property (
    (idle_take && per_en && peripheral_idle_control_q[PER_PIO]) |=> periph_off[PER_PIO]
  ) else $error("parallel gpio not idled");

  chk_zero_wakes: assert property (
    idle_take |=> ((periph_off & ~$past(peripheral_idle_control_q)) == PER_NONE)
  ) else $error("peripheral with clear select left idle");

  chk_err_needs_idle: assert property (
    bus_err |-> $past(idle_instr && clk_bad)
  ) else $error("bus error without a bad clock idle");

  chk_clk_needs_all: assert property (
    domain_off[DOM_CLK] |-> ((domain_off & CLK_NEEDS_MASK) == CLK_NEEDS_MASK)
  ) else $error("clock generator stopped alone");

  chk_dom_load: assert property (
    idle_take |=> (domain_off == $past(cfg_q))
  ) else $error("domain requests not loaded on idle");

  chk_off_holds: assert property (
    (!idle_take && !wake_evt) |=> ($stable(domain_off) && $stable(periph_off))
  ) else $error("idle requests changed without an event");

  chk_wake_clears_off: assert property (
    (wake_evt && !idle_instr) |=> ((domain_off == DOM_NONE) && (periph_off == PER_NONE))
  ) else $error("wake left a request standing");

  chk_status_needs_req: assert property (
    ((status_q & ~$past(dom_off_q)) == DOM_NONE)
  ) else $error("status set without a request");

  chk_status_needs_ack: assert property (
    ((status_q & ~$past(domain_stopped)) == DOM_NONE)
  ) else $error("status set before the domain stopped");

  chk_sleep_all_stopped: assert property (
    $rose(sleep_done) |-> $past(pending == DOM_NONE)
  ) else $error("sleep reported with a domain still running");

  chk_sleep_drops_wake: assert property (
    (sleep_done && wake_evt && !idle_instr) |=> !sleep_done
  ) else $error("sleep kept after wake");

  chk_peripheral_idle_control_upper_zero: assert property (
    (bus_req.rd && hit_peripheral_idle_control) |=> (rd_data[DATA_W-1:NUM_PER] == 2'h0)
  ) else $error("reserved control bits not zero");

  chk_status_read_only: assert property (
    (bus_req.wr && hit_status) |=> ($stable(cfg_q) && $stable(peripheral_idle_control_q))
  ) else $error("status write changed a register");

  chk_unmapped_zero: assert property (
    (bus_req.rd && !hit_status && !hit_peripheral_idle_control && !hit_cfg) |=> (rd_data == READ_ZERO)
  ) else $error("unmapped read not zero");

  cov_full_sleep: cover property (
    idle_take ##1 (state_q == STOPPING_ST) ##[1:8] sleep_done
  );

  cov_bus_error: cover property (
    idle_instr && clk_bad
  );

  cov_per_rewake: cover property (
    (idle_take && per_en) ##[1:20] (idle_take && !per_en)
  );

  cov_wake_from_sleep: cover property (
    sleep_done ##1 wake_evt ##1 !sleep_done
  );

endmodule // idle_ctrl
`default_nettype wire

// [idle_pkg.sv]
`default_nettype none
package idle_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_DOM = 9;
  localparam int unsigned NUM_PER = 14;
  localparam logic [ADDR_W-1:0] IDLE_CFG_OFS = 16'h0001;
  localparam logic [ADDR_W-1:0] IDLE_STATUS_OFS = 16'h0002;
  localparam logic [ADDR_W-1:0] PERIPH_CTRL_OFS = 16'h9400;
  localparam int unsigned DOM_CPU = 0;
  localparam int unsigned DOM_DMA_HOST = 1;
  localparam int unsigned DOM_INSTRUCTION_CACHE = 2;
  localparam int unsigned DOM_PERIPH = 3;
  localparam int unsigned DOM_CLK = 4;
  localparam int unsigned DOM_EXTERNAL_MEMORY_INTERFACE = 5;
  localparam int unsigned DOM_IO_PORT = 6;
  localparam int unsigned DOM_MASTER_PORT = 7;
  localparam int unsigned DOM_INSTRUCTION_CACHE_PORT = 8;
  localparam int unsigned PER_PIO = 9;
  localparam int unsigned PER_WDT = 10;
  localparam int unsigned PER_OS_TIMER = 11;
  localparam int unsigned PER_EXTERNAL_MEMORY_INTERFACE = 12;
  localparam int unsigned PER_MISC = 13;
  localparam logic [NUM_DOM-1:0] CLK_NEEDS_MASK = 9'h1f7;
  localparam logic [NUM_DOM-1:0] DOM_NONE = 9'h000;
  localparam logic [NUM_PER-1:0] PER_WR_MASK = 14'h3fff;
  localparam logic [NUM_PER-1:0] PER_SEL_MASK = 14'h3fef;
  localparam logic [NUM_PER-1:0] PER_NONE = 14'h0000;
  localparam logic [NUM_DOM-1:0] CFG_RESET = 9'h000;
  localparam logic [NUM_PER-1:0] PERIPHERAL_IDLE_CONTROL_RESET = 14'h0000;
  localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef enum logic [2:0] {
    RUN_ST = 3'b001,
    STOPPING_ST = 3'b010,
    ASLEEP_ST = 3'b100
  } pwr_state_t;
endpackage
`default_nettype wire

// [core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Core issuing IDLE and the domains answering it; slow mode stretches the stop answer
module core_model
  import idle_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic go_idle,
  input wire logic go_wake,
  input wire logic slow,
  input wire logic [NUM_DOM-1:0] domain_off,
  output logic idle_instr,
  output logic wake_evt,
  output logic [NUM_DOM-1:0] domain_stopped
);
  logic [NUM_DOM-1:0] dly_q [4];
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      idle_instr <= 1'b0;
      wake_evt <= 1'b0;
      for (int i = 0; i < 4; i++) dly_q[i] <= DOM_NONE;
    end else begin
      idle_instr <= go_idle;
      wake_evt <= go_wake;
      dly_q[0] <= domain_off;
      for (int i = 1; i < 4; i++) dly_q[i] <= dly_q[i-1];
    end
  end
  // A domain drops its stopped level as soon as the request goes, never before it
  assign domain_stopped = slow ? (dly_q[3] & domain_off) : (dly_q[0] & domain_off);
endmodule // core_model
`default_nettype wire

// [idle_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module idle_ctrl_tb;
  import idle_pkg::*;
  logic sys_clk, rstn, go_idle, go_wake, slow, idle_instr, wake_evt, bus_err, sleep_done;
  reg_req_t rq;
  logic [DATA_W-1:0] rd_data;
  logic [NUM_DOM-1:0] domain_stopped, domain_off;
  logic [NUM_PER-1:0] periph_off;
  int failures = 0;
  int checks = 0;
  int errs = 0;
  int doms [7] = '{0, 1, 2, 5, 6, 7, 8};
  idle_ctrl u_idle_ctrl (.sys_clk(sys_clk), .rstn(rstn), .bus_req(rq), .rd_data(rd_data),
    .idle_instr(idle_instr), .wake_evt(wake_evt), .domain_stopped(domain_stopped),
    .domain_off(domain_off), .periph_off(periph_off), .bus_err(bus_err),
    .sleep_done(sleep_done));
  core_model u_core_model (.sys_clk(sys_clk), .rstn(rstn), .go_idle(go_idle),
    .go_wake(go_wake), .slow(slow), .domain_off(domain_off), .idle_instr(idle_instr),
    .wake_evt(wake_evt), .domain_stopped(domain_stopped));
  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (bus_err === 1'b1) errs++;
  task close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk); rq.wr <= 1'b1; rq.addr <= a; rq.wdata <= d;
    @(posedge sys_clk); rq.wr <= 1'b0;
  endtask
  task rdc(input logic [15:0] a, input logic [15:0] e, input string n);
    @(posedge sys_clk); rq.rd <= 1'b1; rq.addr <= a;
    @(posedge sys_clk); rq.rd <= 1'b0;
    #1 chk(n, rd_data, e);
  endtask
  // Fixed settle time covers the slow stop answer plus the registered status
  task pulse(input logic w);
    @(posedge sys_clk); if (w) go_wake <= 1'b1; else go_idle <= 1'b1;
    @(posedge sys_clk); go_wake <= 1'b0; go_idle <= 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    #100000;
    failures++;
    close_out();
  end
  initial begin
    rstn = 1'b0; rq = '0; go_idle = 1'b0; go_wake = 1'b0; slow = 1'b0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    rdc(IDLE_STATUS_OFS, 16'h0000, "status");
    rdc(16'h1234, 16'h0000, "unmapped");
    wr(PERIPH_CTRL_OFS, 16'hffff);
    wr(IDLE_STATUS_OFS, 16'hffff);
    rdc(PERIPH_CTRL_OFS, 16'h3fff, "peripheral_idle_control");
    rdc(IDLE_STATUS_OFS, 16'h0000, "status ro");
    wr(IDLE_CFG_OFS, 16'h0009); slow <= 1'b1;
    pulse(1'b0);
    chk("periph_off", 16'(periph_off), 16'h3fef);
    chk("sleep_done", 16'(sleep_done), 16'h0001);
    rdc(IDLE_STATUS_OFS, 16'h0009, "status");
    wr(PERIPH_CTRL_OFS, 16'h01ef);
    pulse(1'b0);
    chk("periph_off", 16'(periph_off), 16'h01ef);
    wr(IDLE_CFG_OFS, 16'h0001);
    pulse(1'b0);
    chk("periph_off", 16'(periph_off), 16'h0000);
    rdc(IDLE_STATUS_OFS, 16'h0001, "status");
    slow <= 1'b0;
    foreach (doms[i]) begin
      wr(IDLE_CFG_OFS, 16'h0001 << doms[i]);
      pulse(1'b0);
      rdc(IDLE_STATUS_OFS, 16'h0001 << doms[i], "status dom");
    end
    // Clock idle without the other domains must be refused and leave the last request
    wr(IDLE_CFG_OFS, 16'h0011);
    pulse(1'b0);
    chk("bus_err", 16'(errs), 16'h0001);
    chk("domain_off", 16'(domain_off), 16'h0100);
    wr(IDLE_CFG_OFS, 16'h01f7);
    pulse(1'b0);
    rdc(IDLE_STATUS_OFS, 16'h01f7, "status clk");
    chk("bus_err", 16'(errs), 16'h0001);
    chk("sleep_done", 16'(sleep_done), 16'h0001);
    rdc(IDLE_CFG_OFS, 16'h01f7, "cfg");
    pulse(1'b1);
    rdc(IDLE_STATUS_OFS, 16'h0000, "status wake");
    chk("domain_off", 16'(domain_off), 16'h0000);
    chk("periph_off", 16'(periph_off), 16'h0000);
    chk("sleep_done", 16'(sleep_done), 16'h0000);
    close_out();
  end
endmodule // idle_ctrl_tb
`default_nettype wire
